/* dv/adcs_link_asserts.sv */
// Concurrent checks on the link signals between the converter end and the host end.
// Assumes the host makes the bit clock from ref_clk, so bit clock edges fall on ref_clk edges.
`timescale 1ns/1ns
module adcs_link_asserts #(
    parameter int CONV_CYC = 90
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic convRead_n,
    input wire logic busy_n,
    input wire logic serialData,
    input wire logic syncMarker,
    input wire logic clockSourceSelect,
    input wire logic hostBitClk,
    input wire logic serialBitClock
);
    int busyCnt_q;

    // Counts the cycles of an ongoing conversion
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busyCnt_q <= 0;
        end else if (!busy_n) begin
            busyCnt_q <= busyCnt_q + 1;
        end else begin
            busyCnt_q <= 0;
        end
    end

    // Start request, then a conversion that holds busy
    sequence s_start;
        !cs_n && !convRead_n && busy_n;
    endsequence
    sequence s_busy_hold;
        !busy_n [*8];
    endsequence
    sequence s_marker_on;
        $rose(syncMarker);
    endsequence

    property p_busy_start;
        @(posedge ref_clk) disable iff (!resetn) s_start |=> s_busy_hold;
    endproperty
    property p_conv_len;
        @(posedge ref_clk) disable iff (!resetn) $rose(busy_n) |-> busyCnt_q inside {[CONV_CYC-1:CONV_CYC+1]};
    endproperty
    property p_data_edge;
        @(posedge ref_clk) disable iff (!resetn) $changed(serialData) |-> $rose(serialBitClock) || cs_n || !convRead_n;
    endproperty
    property p_marker_edge;
        @(posedge ref_clk) disable iff (!resetn) $changed(syncMarker) |-> $rose(serialBitClock);
    endproperty
    property p_marker_width;
        @(posedge serialBitClock) disable iff (!resetn) s_marker_on |=> !syncMarker [*8];
    endproperty
    property p_marker_window;
        @(posedge ref_clk) disable iff (!resetn) syncMarker |-> (!cs_n && convRead_n);
    endproperty
    property p_select;
        @(posedge ref_clk) disable iff (!resetn) clockSourceSelect;
    endproperty
    property p_setup;
        @(posedge ref_clk) disable iff (!resetn) $rose(hostBitClk) && !cs_n && convRead_n |-> $past(convRead_n);
    endproperty

    a_busy_start: assert property (p_busy_start) else $error("busy did not follow start");
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    a_data_edge: assert property (p_data_edge) else $error("data moved off a rising edge");
    a_marker_edge: assert property (p_marker_edge) else $error("marker moved off a rising edge");
    a_marker_width: assert property (p_marker_width) else $error("marker longer than one pulse");
    a_marker_window: assert property (p_marker_window) else $error("marker outside read");
    a_select: assert property (p_select) else $error("clock source not host");
    a_setup: assert property (p_setup) else $error("pulse too soon after strobe");
endmodule : adcs_link_asserts

/* dv/test_adc_ext_clock_serial_readout.sv */
// Top bench: host end and converter end joined by the link bundle, with the link checker.
// Assumes both ends run on one 20 MHz clock; the host makes the bit clock by division.
`timescale 1ns/1ns
module test_adc_ext_clock_serial_readout
    import adcs_pkg::*;
;
    localparam int CONV = 90;
    logic                ref_clk;
    logic                resetn;
    logic [RESULT_W-1:0] sampleIn;
    logic                continuousClk;
    logic                startValid;
    logic                startReady;
    logic                readDuring;
    logic                useMarker;
    logic                resultValid;
    logic                resultReady;
    logic [RESULT_W-1:0] resultData;
    logic [RESULT_W-1:0] wireWord;
    logic                markSeen;
    logic [33:0]         rows [6];
    int                  fallCnt;
    int                  fails;
    int                  checksDone;
    int                  i;
    int                  n;

    adcs_link_if link ();
    adcs_device #(.CONV_CYC(CONV)) adcs_device_inst (.ref_clk(ref_clk), .resetn(resetn), .sampleIn(sampleIn),
        .continuousClk(continuousClk), .link(link));
    adcs_host adcs_host_inst (.ref_clk(ref_clk), .resetn(resetn), .startValid(startValid),
        .startReady(startReady), .readDuring(readDuring), .useMarker(useMarker), .resultValid(resultValid),
        .resultReady(resultReady), .resultData(resultData), .link(link));
    adcs_link_asserts #(.CONV_CYC(CONV)) adcs_link_asserts_inst (.ref_clk(ref_clk), .resetn(resetn),
        .cs_n(link.cs_n), .convRead_n(link.convRead_n), .busy_n(link.busy_n), .serialData(link.serialData),
        .syncMarker(link.syncMarker), .clockSourceSelect(link.clockSourceSelect),
        .hostBitClk(link.hostBitClk), .serialBitClock(link.serialBitClock));

    // Reference clock
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;

    // Wire monitor: collects bits on falling bit clock edges inside the read window
    always @(negedge link.serialBitClock) begin
        if (link.cs_n === 1'b0 && link.convRead_n === 1'b1) begin
            fallCnt = fallCnt + 1;
            if (fallCnt == 1) markSeen = link.syncMarker;
            wireWord = {wireWord[RESULT_W-2:0], link.serialData};
        end
    end

    task automatic stop_test;
        if (fails == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic report(input string what);
        fails++;
        $display("CHECK FAILED at %0t: %s", $time, what);
    endtask : report

    task automatic check_word(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
        checksDone++;
        if (got !== exp) report($sformatf("word %h, expected %h", got, exp));
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) report($sformatf("bit %b, expected %b", got, exp));
    endtask : check_bit

    task automatic check_int(input int got, input int exp);
        checksDone++;
        if (got != exp) report($sformatf("count %0d, expected %0d", got, exp));
    endtask : check_int

    task automatic tick;
        @(posedge ref_clk);
        #5;
    endtask : tick

    // Presents one start request and holds it until the host takes it
    task automatic start_req(input logic rd, input logic mk, input logic [RESULT_W-1:0] smp);
        int k;
        readDuring = rd;
        useMarker = mk;
        sampleIn = smp;
        fallCnt = 0;
        startValid = 1'b1;
        for (k = 0; startReady !== 1'b1; k++) begin
            if (k == 400) begin
                report("start wait ran out");
                stop_test();
            end
            tick();
        end
        tick();
        startValid = 1'b0;
    endtask : start_req

    // One full conversion and read, checked at the user side and on the wire
    task automatic do_seq(input logic rd, input logic mk, input logic [RESULT_W-1:0] smp,
                          input logic [RESULT_W-1:0] exp);
        int k;
        start_req(rd, mk, smp);
        for (k = 0; resultValid !== 1'b1; k++) begin
            if (k == 400) begin
                report("result wait ran out");
                stop_test();
            end
            tick();
        end
        check_word(resultData, exp);
        check_word(wireWord, exp);
        check_int(fallCnt, mk ? MARKER_PULSES : PLAIN_PULSES);
        check_bit(markSeen, mk);
        resultReady = 1'b1;
        tick();
        resultReady = 1'b0;
    endtask : do_seq

    initial begin
        fails = 0;
        checksDone = 0;
        resetn = 1'b0;
        sampleIn = 16'h0000;
        continuousClk = 1'b0;
        startValid = 1'b0;
        readDuring = 1'b0;
        useMarker = 1'b0;
        resultReady = 1'b0;
        fallCnt = 0;
        markSeen = 1'b0;
        wireWord = 16'h0000;
        // Columns: read during, marker, sample, expected word
        rows = '{{2'b00, RES_POS_FS, RES_POS_FS}, {2'b01, RES_MIDSCALE, RES_MIDSCALE},
                 {2'b10, RES_BELOW_MID, RES_MIDSCALE}, {2'b11, RES_NEG_FS, RES_BELOW_MID},
                 {2'b01, 16'h1234, 16'h1234}, {2'b10, 16'ha5a5, 16'h1234}};
        repeat (5) tick();
        check_bit(link.busy_n, 1'b1);
        check_bit(link.cs_n, 1'b1);
        check_bit(resultValid, 1'b0);
        tick();
        resetn = 1'b1;
        tick();
        check_bit(startReady, 1'b1);
        for (i = 0; i < 6; i++) begin
            do_seq(rows[i][33], rows[i][32], rows[i][31:16], rows[i][15:0]);
        end
        // Fill the result buffer while the user side stalls, then drain it
        for (i = 0; i < 32; i++) begin
            start_req(1'b0, 1'b1, 16'h00ff);
        end
        startValid = 1'b1;
        n = 0;
        for (i = 0; i < 300; i++) begin
            if (startReady === 1'b1) n++;
            tick();
        end
        startValid = 1'b0;
        check_int(n, 0);
        resultReady = 1'b1;
        for (i = 0; i < 32; i++) begin
            check_bit(resultValid, 1'b1);
            check_word(resultData, 16'h00ff);
            tick();
        end
        resultReady = 1'b0;
        check_bit(resultValid, 1'b0);
        // Reset in the start phase of a read during conversion, while busy is low and before any bit is read
        start_req(1'b1, 1'b1, 16'h4321);
        repeat (2) tick();
        resetn = 1'b0;
        tick();
        check_bit(link.busy_n, 1'b1);
        check_bit(link.syncMarker, 1'b0);
        check_bit(link.convRead_n, 1'b1);
        resetn = 1'b1;
        tick();
        do_seq(1'b0, 1'b0, 16'h0f0f, 16'h0f0f);
        // Free-running clock: marker comes unasked, so a plain host sees it as the first bit
        continuousClk = 1'b1;
        start_req(1'b0, 1'b0, 16'h5a5a);
        for (i = 0; resultValid !== 1'b1 && i < 400; i++) tick();
        check_bit(resultValid, 1'b1);
        check_bit(markSeen, 1'b1);
        check_word(resultData, 16'h2d2d);
        stop_test();
    end
endmodule : test_adc_ext_clock_serial_readout

/* logic/adcs_device.sv */
// Converter end: conversion control on ref_clk, serial shifter on the bit clock.
// Assumes strobes come from logic on ref_clk and settle before each bit clock edge.
`timescale 1ns/1ns
module adcs_device
    import adcs_pkg::*;
#(
    parameter int CONV_CYC = 90,  // Conversion length in ref_clk cycles
    parameter int INT_HALF = 1    // Half period of the own bit clock in ref_clk cycles
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic [RESULT_W-1:0] sampleIn,
    input  wire logic                continuousClk,
    adcs_link_if.device              link
);

    localparam int LOW_W = 4;
    localparam int CNT_W = $clog2(CONV_CYC + 1);
    localparam int INT_W = $clog2(2 * PLAIN_PULSES * INT_HALF + 2);
    localparam int POS_W = 5;

    // ---------------- ref_clk domain ----------------
    logic                startCond;
    logic [LOW_W-1:0]    lowCnt_q;
    logic                busy_q;
    logic [CNT_W-1:0]    convCnt_q;
    logic [RESULT_W-1:0] convWord_q;
    logic [RESULT_W-1:0] doneWord_q;
    logic                convStart;
    logic                intRun_q;
    logic [INT_W-1:0]    intCnt_q;
    logic [INT_W-1:0]    intHalf_q;
    logic                devClk_q;

    // Both strobes low means start, as the two are ORed
    assign startCond = !link.cs_n && !link.convRead_n;
    assign convStart = startCond && !busy_q && (lowCnt_q == LOW_W'(STROBE_MIN_CYC - 1));

    // Count how long the strobes have overlapped, saturating so one overlap starts once
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lowCnt_q <= '0;
        end else if (!startCond) begin
            lowCnt_q <= '0;
        end else if (lowCnt_q != LOW_W'(STROBE_MIN_CYC)) begin
            lowCnt_q <= lowCnt_q + LOW_W'(1);
        end
    end

    // Busy falls on the very edge that sees the start, inside BUSY_MAX_CYC
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q    <= 1'b0;
            convCnt_q <= '0;
        end else if (convStart) begin
            busy_q    <= 1'b1;
            convCnt_q <= CNT_W'(CONV_CYC - 1);
        end else if (busy_q) begin
            if (convCnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                convCnt_q <= convCnt_q - CNT_W'(1);
            end
        end
    end

    assign link.busy_n = !busy_q;

    // Sample is held at the start; the finished word replaces the previous one at the end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            convWord_q <= RES_MIDSCALE;
            doneWord_q <= RES_MIDSCALE; // First result after power up is meaningless
        end else begin
            if (convStart) begin
                convWord_q <= sampleIn;
            end
            if (busy_q && convCnt_q == '0) begin
                doneWord_q <= convWord_q;
            end
        end
    end

    // Own bit clock: a burst of sixteen pulses per conversion when the host gives none
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            intRun_q  <= 1'b0;
            intCnt_q  <= '0;
            intHalf_q <= '0;
            devClk_q  <= 1'b0;
        end else if (convStart && !link.clockSourceSelect) begin
            intRun_q  <= 1'b1;
            intCnt_q  <= INT_W'(2 * PLAIN_PULSES);
            intHalf_q <= INT_W'(INT_HALF - 1);
        end else if (intRun_q) begin
            if (intHalf_q != '0) begin
                intHalf_q <= intHalf_q - INT_W'(1);
            end else if (intCnt_q == '0) begin
                intRun_q <= 1'b0;
                devClk_q <= 1'b0; // Parks low after the last bit
            end else begin
                intHalf_q <= INT_W'(INT_HALF - 1);
                intCnt_q  <= intCnt_q - INT_W'(1);
                devClk_q  <= !devClk_q;
            end
        end
    end

    assign link.devBitClk = devClk_q;

    // ---------------- bit clock domain ----------------
    // The result word is quasi-static here: it only changes when busy rises,
    // and a legal read never spans that instant, so it is sampled directly.
    logic             readCond;
    logic             frameRst_n;
    logic             armed_q;
    logic             markerOn;
    logic             frameMark_q;
    logic             useMark;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] lastPos;
    logic [POS_W-1:0] bitIdx;
    logic             dataOut_q;
    logic             marker_q;

    // Reading window: chip select low with the strobe high
    assign readCond   = !link.cs_n && link.convRead_n;
    // The frame ends with its own signal, since the bit clock may stop at any time
    assign frameRst_n = resetn && readCond;

    // Marker enabled by arming or always with a free-running clock, never with the own clock
    assign markerOn = link.clockSourceSelect && (armed_q || continuousClk);
    assign useMark  = (pos_q == '0) ? markerOn : frameMark_q;
    assign lastPos  = useMark ? POS_W'(MARKER_PULSES - 1) : POS_W'(PLAIN_PULSES - 1);
    assign bitIdx   = useMark ? POS_W'(RESULT_W) - pos_q : POS_W'(RESULT_W - 1) - pos_q;

    // Any edge outside the reading window arms the marker; the frame's last edge disarms it
    always_ff @(posedge link.serialBitClock or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else if (!readCond) begin
            armed_q <= 1'b1;
        end else if (pos_q == lastPos) begin
            armed_q <= 1'b0;
        end
    end

    // Edge counter and marker choice for the current frame
    always_ff @(posedge link.serialBitClock or negedge frameRst_n) begin
        if (!frameRst_n) begin
            pos_q       <= '0;
            frameMark_q <= 1'b0;
        end else if (pos_q <= lastPos) begin
            pos_q <= pos_q + POS_W'(1);
            if (pos_q == '0) begin
                frameMark_q <= markerOn;
            end
        end
    end

    // Outputs change just after each rising edge and hold to the next rising edge
    always_ff @(posedge link.serialBitClock or negedge frameRst_n) begin
        if (!frameRst_n) begin
            dataOut_q <= 1'b0;
            marker_q  <= 1'b0;
        end else if (pos_q > lastPos) begin
            dataOut_q <= 1'b0;
            marker_q  <= 1'b0;
        end else if (useMark && pos_q == '0) begin
            dataOut_q <= 1'b0;
            marker_q  <= 1'b1;
        end else begin
            dataOut_q <= doneWord_q[bitIdx[3:0]];
            marker_q  <= 1'b0;
        end
    end

    assign link.serialData = dataOut_q;
    assign link.syncMarker = marker_q;

endmodule : adcs_device

/* logic/adcs_host.sv */
// Host end: drives strobes, makes the bit clock by division, collects words into a FIFO.
// Assumes the converter end shares ref_clk; the bit clock is made here, so no crossing.
`timescale 1ns/1ns
module adcs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wrPtr_q;
    logic [AW:0]      rdPtr_q;
    logic             doWr;
    logic             doRd;

    // Full when pointers differ only in the wrap bit
    assign inReady  = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
    assign outValid = (wrPtr_q != rdPtr_q);
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem_q[rdPtr_q[AW-1:0]];

    // Storage
    always_ff @(posedge ref_clk) begin
        if (doWr) begin
            mem_q[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    // Pointers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (doWr) begin
                wrPtr_q <= wrPtr_q + (AW+1)'(1);
            end
            if (doRd) begin
                rdPtr_q <= rdPtr_q + (AW+1)'(1);
            end
        end
    end
endmodule : adcs_fifo

module adcs_host
    import adcs_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                startValid,
    output logic                     startReady,
    input  wire logic                readDuring,
    input  wire logic                useMarker,
    output logic                     resultValid,
    input  wire logic                resultReady,
    output logic      [RESULT_W-1:0] resultData,
    adcs_link_if.host                link
);
    localparam int TW = 3;
    localparam int PW = 5;

    adcs_host_state_type state_q;
    logic [TW-1:0]       timer_q;
    logic [PW-1:0]       pulse_q;
    logic                during_q;
    logic                marker_q;
    logic                cs_n_q;
    logic                convRead_n_q;
    logic                clk_q;
    logic [RESULT_W-1:0] word_q;
    logic                push;
    logic                fifoReady;
    logic [PW-1:0]       lastPulse;

    assign startReady = (state_q == HS_IDLE) && fifoReady;
    assign push       = (state_q == HS_FINISH) && link.busy_n && fifoReady;
    // Falling-edge capture needs sixteen pulses, one more for the marker
    assign lastPulse  = marker_q ? PW'(MARKER_PULSES) : PW'(PLAIN_PULSES);

    // Sequencer; discontinuous clock only, chip select driven rather than tied
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q      <= HS_IDLE;
            timer_q      <= '0;
            pulse_q      <= '0;
            during_q     <= 1'b0;
            marker_q     <= 1'b0;
            cs_n_q       <= 1'b1;
            convRead_n_q <= 1'b1;
            clk_q        <= 1'b0;
            word_q       <= '0;
        end else begin
            unique case (state_q)
                HS_IDLE: begin
                    if (startValid && fifoReady) begin
                        during_q     <= readDuring;
                        marker_q     <= useMarker;
                        cs_n_q       <= 1'b0;
                        convRead_n_q <= 1'b0;
                        timer_q      <= TW'(START_CYC - 1);
                        clk_q        <= 1'b0;
                        state_q      <= HS_START;
                    end
                end
                HS_START: begin
                    // Pulse zero with both strobes low arms the marker; it ends before the strobe rises
                    if (timer_q != '0) begin
                        clk_q   <= during_q && marker_q && (timer_q == TW'(START_CYC - 1));
                        timer_q <= timer_q - TW'(1);
                    end else if (clk_q) begin
                        clk_q <= 1'b0;
                    end else begin
                        convRead_n_q <= 1'b1;
                        state_q      <= HS_WAIT_LO;
                    end
                end
                HS_WAIT_LO: begin
                    if (!link.busy_n) begin
                        timer_q <= TW'(SYNC_SETUP_CYC - 1);
                        state_q <= during_q ? HS_SETUP : HS_WAIT_HI;
                    end
                end
                HS_WAIT_HI: begin
                    if (link.busy_n) begin
                        timer_q <= '0;
                        state_q <= marker_q ? HS_ARM : HS_SETUP;
                    end
                end
                HS_ARM: begin
                    // Chip select up, pulse zero, then chip select down; never two moves at once
                    timer_q <= timer_q + TW'(1);
                    cs_n_q  <= (timer_q != TW'(3));
                    clk_q   <= (timer_q == TW'(1));
                    if (timer_q == TW'(3)) begin
                        timer_q <= TW'(SYNC_SETUP_CYC - 1);
                        state_q <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (timer_q == '0) begin
                        pulse_q <= '0;
                        state_q <= HS_CLOCK;
                    end else begin
                        timer_q <= timer_q - TW'(1);
                    end
                end
                HS_CLOCK: begin
                    // One ref_clk cycle per half period gives a 10 MHz bit clock
                    if (!clk_q) begin
                        clk_q   <= 1'b1;
                        pulse_q <= pulse_q + PW'(1);
                    end else begin
                        clk_q <= 1'b0;
                        if (!marker_q || pulse_q != PW'(1)) begin
                            word_q <= {word_q[RESULT_W-2:0], link.serialData};
                        end
                        if (pulse_q == lastPulse) begin
                            state_q <= HS_FINISH;
                        end
                    end
                end
                HS_FINISH: begin
                    // Waits for busy to rise and for room in the FIFO
                    if (push) begin
                        state_q <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cs_n              = cs_n_q;
    assign link.convRead_n        = convRead_n_q;
    assign link.hostBitClk        = clk_q;
    assign link.clockSourceSelect = 1'b1;

    adcs_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .inValid  (push),
        .inReady  (fifoReady),
        .inData   (word_q),
        .outValid (resultValid),
        .outReady (resultReady),
        .outData  (resultData)
    );

endmodule : adcs_host

/* logic/adcs_link_if.sv */
// Pin bundle between the converter end and the host end.
// Resolves the shared bit clock wire from the clock source select level.
`timescale 1ns/1ns
interface adcs_link_if;
    logic cs_n;              // Chip select, active low
    logic convRead_n;        // Convert when low, read when high
    logic busy_n;            // Conversion in progress, active low
    logic serialData;        // Result bits
    logic syncMarker;        // Frame marker pulse
    logic clockSourceSelect; // High: host makes the bit clock
    logic hostBitClk;        // Bit clock made by the host
    logic devBitClk;         // Bit clock made by the converter
    logic serialBitClock;    // Resolved bit clock wire

    assign serialBitClock = clockSourceSelect ? hostBitClk : devBitClk;

    modport device (
        input  cs_n,
        input  convRead_n,
        input  clockSourceSelect,
        input  serialBitClock,
        output busy_n,
        output serialData,
        output syncMarker,
        output devBitClk
    );

    modport host (
        output cs_n,
        output convRead_n,
        output clockSourceSelect,
        output hostBitClk,
        input  busy_n,
        input  serialData,
        input  syncMarker
    );
endinterface : adcs_link_if

/* logic/adcs_pkg.sv */
// Constants, codes and state types shared by both ends of the serial readout link.
// Assumes both ends see the same 20 MHz reference clock; the bit clock is a separate domain.
//
// Function
// - Clock source select picks host or own clock
// - Both strobes low at least 50 ns starts
// - Continuous clock always gives frame marker
// - Busy low: shift previous result while reading
// - Busy high again: shift newest result
// - No marker: MSB falling 1, LSB falling 16
// - Falling-edge host supplies sixteen or more pulses
// - Read during conversion fast, at 10 MHz
// - Clock edge outside read condition arms marker
// - Marker after rising edge pulse one
// - With marker: MSB pulse two, LSB seventeen
// - Busy falls within 83 ns of start
// - Host waits 15 ns before pulse one
// - Read during conversion: MSB after pulse two; the code does so only with marker, after pulse one without it
// - Continuous clock host must drive chip select
// - Discontinuous host may tie chip select low
// - Read after conversion limits throughput near 195 kHz
// - Result coded as 16-bit straight binary
package adcs_pkg;

    localparam int REF_PERIOD_NS    = 50;
    localparam int REF_KHZ          = 20000;
    localparam int RESULT_W         = 16;

    // Start strobe overlap, least time rounds up
    localparam int STROBE_MIN_NS    = 50;
    localparam int STROBE_MIN_CYC   = (STROBE_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    // Busy response, longest time rounds down, never below one cycle
    localparam int BUSY_MAX_NS      = 83;
    localparam int BUSY_MAX_CYC     = (BUSY_MAX_NS / REF_PERIOD_NS) < 1 ? 1 : BUSY_MAX_NS / REF_PERIOD_NS;
    // Strobe high to first bit clock pulse, least time rounds up
    localparam int SYNC_SETUP_NS    = 15;
    localparam int SYNC_SETUP_CYC   = (SYNC_SETUP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    // Lowest bit clock for reading during a conversion
    localparam int BIT_CLK_MIN_KHZ  = 10000;
    localparam int HOST_HALF_CYC    = REF_KHZ / (2 * BIT_CLK_MIN_KHZ);
    // Host start phase: strobe overlap plus one cycle for the arming pulse
    localparam int START_CYC        = STROBE_MIN_CYC + 1;

    // Pulses per frame without and with the frame marker
    localparam int PLAIN_PULSES     = 16;
    localparam int MARKER_PULSES    = 17;

    // Straight binary code points
    localparam logic [15:0] RES_POS_FS    = 16'hffff;
    localparam logic [15:0] RES_MIDSCALE  = 16'h8000;
    localparam logic [15:0] RES_BELOW_MID = 16'h7fff;
    localparam logic [15:0] RES_NEG_FS    = 16'h0000;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_START,
        HS_WAIT_LO,
        HS_WAIT_HI,
        HS_ARM,
        HS_SETUP,
        HS_CLOCK,
        HS_FINISH
    } adcs_host_state_type;

endpackage : adcs_pkg
